// ===== hdl/trc_consts.svh
`ifndef TRC_CONSTS_SVH
`define TRC_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define TRC_OFF_CFG1 8'h00
`define TRC_OFF_GAIN 8'h04
`define TRC_OFF_OFFS 8'h08
`define TRC_OFF_RESULT 8'h0C
`define TRC_OFF_ZERO 8'h10
`define TRC_OFF_COEFF 8'h14
`define TRC_OFF_CTRL 8'h18
`define TRC_OFF_STATUS 8'h1C
`define TRC_OFF_TEMP 8'h20

// ****************************************
// Fields and reset values
// ****************************************
`define TRC_CFG1_COMP_EN_BIT 6
`define TRC_CFG1_INT_SEL_BIT 8
`define TRC_CTRL_START_BIT 0
`define TRC_STAT_ZERO_BIT 0
`define TRC_STAT_DONE_BIT 1
`define TRC_STAT_BUSY_BIT 2
`define TRC_FACTOR_RST 24'h000000
`define TRC_ZERO_RST 24'h100000
`define TRC_COEFF_RST 24'h0DAC00

// ****************************************
// Arithmetic constants
// ****************************************
`define TRC_RESULT_RAM_ADDR 8'hF5
`define TRC_ONE_Q20 21'h100000
`define TRC_PPM_SCALE 64'h00000000000F4240
`define TRC_NOM_COEFF_PPM 16'h0DAC
`define TRC_DIV_SHIFT 16
`define TRC_TEMP_MAX 24'h7FFFFF

`endif

// ===== hdl/trc_pkg.sv
`default_nettype none
package trc_pkg;
    typedef enum logic [2:0] {
        TRC_IDLE = 3'b001,
        TRC_MULT = 3'b010,
        TRC_DIV = 3'b100
    } trc_state_t;
endpackage : trc_pkg
`default_nettype wire

// ===== hdl/trc_div.sv
`default_nettype none
module trc_div #(
    parameter int NUM_W = 64,
    parameter int DEN_W = 48
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic [NUM_W-1:0] num_i,
    input wire logic [DEN_W-1:0] den_i,
    output logic busy_o,
    output logic done_o,
    output logic [NUM_W-1:0] quot_o
);
    localparam int CNT_W = $clog2(NUM_W + 1);
    logic [NUM_W-1:0] quot_reg;
    logic [DEN_W-1:0] rem_reg;
    logic [DEN_W-1:0] den_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic busy_reg;
    logic done_reg;
    logic [DEN_W:0] trial;

    assign trial = {rem_reg, quot_reg[NUM_W-1]};

    // ****************************************
    // Restoring division, one bit per clock
    // ****************************************
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            quot_reg <= '0;
            rem_reg <= '0;
            den_reg <= '0;
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            if (start_i && !busy_reg)
            begin
                quot_reg <= num_i;
                rem_reg <= '0;
                den_reg <= den_i;
                cnt_reg <= CNT_W'(NUM_W);
                busy_reg <= 1'b1;
            end
            else if (busy_reg)
            begin
                // Full-width remainder keeps all 16 fraction bits exact
                if (trial >= {1'b0, den_reg})
                begin
                    rem_reg <= DEN_W'(trial - {1'b0, den_reg});
                    quot_reg <= {quot_reg[NUM_W-2:0], 1'b1};
                end
                else
                begin
                    rem_reg <= trial[DEN_W-1:0];
                    quot_reg <= {quot_reg[NUM_W-2:0], 1'b0};
                end
                cnt_reg <= cnt_reg - 1'b1;
                if (cnt_reg == CNT_W'(1))
                begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
            end
        end
    end

    assign busy_o = busy_reg;
    assign done_o = done_reg;
    assign quot_o = quot_reg;
endmodule : trc_div
`default_nettype wire

// ===== hdl/trc_top.sv
// Chosen here: the register offsets and the APB slave port.
`include "trc_consts.svh"
`default_nettype none
module trc_top #(
    parameter int FACT_W = 24,
    parameter int FRAC_W = 20
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic temp_valid_i,
    input wire logic [FRAC_W-1:0] temp_word_i,
    output logic comp_active_o,
    output logic internal_sensor_o,
    output logic [FACT_W-1:0] gain_drift_factor_o,
    output logic [FACT_W-1:0] offset_drift_factor_o,
    output logic [23:0] temperature_o,
    output logic temp_done_o
);
    localparam int NUM_W = 64;
    localparam int DEN_W = 48;

    trc_pkg::trc_state_t state_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic comp_en_reg;
    logic int_sel_reg;
    logic [FACT_W-1:0] gain_reg;
    logic [FACT_W-1:0] offs_reg;
    logic [FRAC_W-1:0] result_reg;
    logic [23:0] zero_ratio_reg;
    logic [23:0] effective_coeff_reg;
    logic [23:0] temp_reg;
    logic go_reg;
    logic zero_flag_reg;
    logic done_flag_reg;
    logic done_pulse_reg;
    logic neg_reg;
    logic div_start_reg;
    logic [NUM_W-1:0] num_reg;
    logic [DEN_W-1:0] den_reg;
    logic comp_active_reg;
    logic internal_sensor_reg;
    logic [FACT_W-1:0] gain_out_reg;
    logic [FACT_W-1:0] offs_out_reg;
    logic setup;
    logic wr_en;
    logic mapped;
    logic start_req;
    logic [20:0] current_ratio;
    logic signed [25:0] diff;
    logic [24:0] diff_mag;
    logic div_done;
    logic [NUM_W-1:0] quot;
    logic [23:0] quot_sat;

    // ****************************************
    // APB slave
    // ****************************************
    assign setup = psel_i && !penable_i;
    assign wr_en = psel_i && penable_i && pready_reg && pwrite_i && !pslverr_reg;
    always_comb
    begin
        unique case (paddr_i)
            `TRC_OFF_CFG1, `TRC_OFF_GAIN, `TRC_OFF_OFFS, `TRC_OFF_RESULT,
            `TRC_OFF_ZERO, `TRC_OFF_COEFF, `TRC_OFF_CTRL, `TRC_OFF_STATUS,
            `TRC_OFF_TEMP: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // No wait state, yet read data and ready still come straight from flops
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end
        else
        begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            if (setup && !pwrite_i)
            begin
                prdata_reg <= 32'h00000000;
                unique case (paddr_i)
                    `TRC_OFF_CFG1:
                    begin
                        prdata_reg[`TRC_CFG1_COMP_EN_BIT] <= comp_en_reg;
                        prdata_reg[`TRC_CFG1_INT_SEL_BIT] <= int_sel_reg;
                    end
                    `TRC_OFF_GAIN: prdata_reg[FACT_W-1:0] <= gain_reg;
                    `TRC_OFF_OFFS: prdata_reg[FACT_W-1:0] <= offs_reg;
                    `TRC_OFF_RESULT: prdata_reg[FRAC_W-1:0] <= result_reg;
                    `TRC_OFF_ZERO: prdata_reg[23:0] <= zero_ratio_reg;
                    `TRC_OFF_COEFF: prdata_reg[23:0] <= effective_coeff_reg;
                    `TRC_OFF_STATUS:
                    begin
                        prdata_reg[`TRC_STAT_ZERO_BIT] <= zero_flag_reg;
                        prdata_reg[`TRC_STAT_DONE_BIT] <= done_flag_reg;
                        prdata_reg[`TRC_STAT_BUSY_BIT] <= (state_reg != trc_pkg::TRC_IDLE);
                    end
                    `TRC_OFF_TEMP: prdata_reg[23:0] <= temp_reg;
                    default: prdata_reg <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            comp_en_reg <= 1'b0;
            int_sel_reg <= 1'b0;
            gain_reg <= `TRC_FACTOR_RST;
            offs_reg <= `TRC_FACTOR_RST;
            zero_ratio_reg <= `TRC_ZERO_RST;
            effective_coeff_reg <= `TRC_COEFF_RST;
        end
        else if (wr_en)
        begin
            unique case (paddr_i)
                `TRC_OFF_CFG1:
                begin
                    comp_en_reg <= pwdata_i[`TRC_CFG1_COMP_EN_BIT];
                    int_sel_reg <= pwdata_i[`TRC_CFG1_INT_SEL_BIT];
                end
                `TRC_OFF_GAIN: gain_reg <= pwdata_i[FACT_W-1:0];
                `TRC_OFF_OFFS: offs_reg <= pwdata_i[FACT_W-1:0];
                // Calibrated values come from software storage
                `TRC_OFF_ZERO: zero_ratio_reg <= pwdata_i[23:0];
                `TRC_OFF_COEFF: effective_coeff_reg <= pwdata_i[23:0];
                default:
                begin
                end
            endcase
        end
    end

    // ****************************************
    // Compensation outputs
    // ****************************************
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            comp_active_reg <= 1'b0;
            internal_sensor_reg <= 1'b0;
            gain_out_reg <= `TRC_FACTOR_RST;
            offs_out_reg <= `TRC_FACTOR_RST;
        end
        else
        begin
            comp_active_reg <= comp_en_reg;
            internal_sensor_reg <= int_sel_reg;
            // Factors read as zero so the correction stays neutral when off
            gain_out_reg <= comp_en_reg ? gain_reg : `TRC_FACTOR_RST;
            offs_out_reg <= comp_en_reg ? offs_reg : `TRC_FACTOR_RST;
        end
    end

    // ****************************************
    // Result word capture
    // ****************************************
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            result_reg <= '0;
        end
        else if (temp_valid_i)
        begin
            result_reg <= temp_word_i;
        end
    end

    // ****************************************
    // Temperature computation
    // ****************************************
    assign start_req = temp_valid_i || (wr_en && paddr_i == `TRC_OFF_CTRL
        && pwdata_i[`TRC_CTRL_START_BIT]);
    assign current_ratio = `TRC_ONE_Q20 + {1'b0, result_reg};
    assign diff = $signed({5'b00000, current_ratio}) - $signed({2'b00, zero_ratio_reg});
    assign diff_mag = diff[25] ? 25'(-diff) : diff[24:0];
    assign quot_sat = (|quot[NUM_W-1:23]) ? `TRC_TEMP_MAX : quot[23:0];

    // Request waits while busy; words arriving during one run fold into one later run on the latest word
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            go_reg <= 1'b0;
        end
        else if (start_req)
        begin
            go_reg <= 1'b1;
        end
        else if (state_reg == trc_pkg::TRC_IDLE)
        begin
            go_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_reg <= trc_pkg::TRC_IDLE;
            num_reg <= '0;
            den_reg <= '0;
            neg_reg <= 1'b0;
            div_start_reg <= 1'b0;
        end
        else
        begin
            div_start_reg <= 1'b0;
            unique case (state_reg)
                trc_pkg::TRC_IDLE:
                begin
                    if (go_reg)
                    begin
                        // Result word sampled now, one cycle after capture
                        num_reg <= (64'(diff_mag) * `TRC_PPM_SCALE)
                            << `TRC_DIV_SHIFT;
                        den_reg <= 48'(effective_coeff_reg) * 48'(zero_ratio_reg);
                        neg_reg <= diff[25];
                        state_reg <= trc_pkg::TRC_MULT;
                    end
                end
                trc_pkg::TRC_MULT:
                begin
                    if (den_reg == '0)
                    begin
                        state_reg <= trc_pkg::TRC_IDLE;
                    end
                    else
                    begin
                        div_start_reg <= 1'b1;
                        state_reg <= trc_pkg::TRC_DIV;
                    end
                end
                trc_pkg::TRC_DIV:
                begin
                    if (div_done)
                    begin
                        state_reg <= trc_pkg::TRC_IDLE;
                    end
                end
            endcase
        end
    end

    // Old temperature is kept when the divisor is zero
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            temp_reg <= 24'h000000;
            done_pulse_reg <= 1'b0;
        end
        else
        begin
            done_pulse_reg <= div_done;
            if (div_done)
            begin
                temp_reg <= neg_reg ? 24'(-quot_sat) : quot_sat;
            end
        end
    end

    // Sticky status, set wins over write-one clear
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            zero_flag_reg <= 1'b0;
            done_flag_reg <= 1'b0;
        end
        else
        begin
            if (state_reg == trc_pkg::TRC_MULT && den_reg == '0)
            begin
                zero_flag_reg <= 1'b1;
            end
            else if (wr_en && paddr_i == `TRC_OFF_STATUS && pwdata_i[`TRC_STAT_ZERO_BIT])
            begin
                zero_flag_reg <= 1'b0;
            end
            if (div_done)
            begin
                done_flag_reg <= 1'b1;
            end
            else if (wr_en && paddr_i == `TRC_OFF_STATUS && pwdata_i[`TRC_STAT_DONE_BIT])
            begin
                done_flag_reg <= 1'b0;
            end
        end
    end

    trc_div #(
        .NUM_W(NUM_W),
        .DEN_W(DEN_W)
    ) u_div (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .start_i(div_start_reg),
        .num_i(num_reg),
        .den_i(den_reg),
        .busy_o(),
        .done_o(div_done),
        .quot_o(quot)
    );

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign comp_active_o = comp_active_reg;
    assign internal_sensor_o = internal_sensor_reg;
    assign gain_drift_factor_o = gain_out_reg;
    assign offset_drift_factor_o = offs_out_reg;
    assign temperature_o = temp_reg;
    assign temp_done_o = done_pulse_reg;
endmodule : trc_top
`default_nettype wire

// ===== tb/trc_top_asserts.sv
`default_nettype none
// ****
// Port checker
// ****
module trc_top_asserts #(
    parameter int FACT_W = 24
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic temp_valid_i,
    input wire logic comp_active_o,
    input wire logic internal_sensor_o,
    input wire logic [FACT_W-1:0] gain_drift_factor_o,
    input wire logic [FACT_W-1:0] offset_drift_factor_o,
    input wire logic [23:0] temperature_o,
    input wire logic temp_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Divisor shadows: a zero term must suppress the result
    logic [23:0] zero_reg;
    logic [23:0] coeff_reg;
    wire logic wr_acc = psel_i && penable_i && pready_o && pwrite_i;
    wire logic setup = psel_i && !penable_i;
    wire logic mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= 8'h20);
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            zero_reg <= 24'h100000;
            coeff_reg <= 24'h0DAC00;
        end
        else if (wr_acc && paddr_i == 8'h10)
            zero_reg <= pwdata_i[23:0];
        else if (wr_acc && paddr_i == 8'h14)
            coeff_reg <= pwdata_i[23:0];
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    property p_answer;
        setup |=> pready_o ##1 !pready_o;
    endproperty
    a_answer: assert property (p_answer) else $error("bad answer");
    property p_err;
        setup |=> pslverr_o == !$past(mapped);
    endproperty
    a_err: assert property (p_err) else $error("bad slave error");
    property p_en;
        wr_acc && paddr_i == 8'h00 |-> ##2 comp_active_o == $past(pwdata_i[6], 2);
    endproperty
    a_en: assert property (p_en) else $error("enable not copied");
    property p_sel;
        wr_acc && paddr_i == 8'h00 |-> ##2 internal_sensor_o == $past(pwdata_i[8], 2);
    endproperty
    a_sel: assert property (p_sel) else $error("select not copied");
    property p_gated;
        !comp_active_o [*3]
            |-> $past(gain_drift_factor_o) == '0 && $past(offset_drift_factor_o) == '0;
    endproperty
    a_gated: assert property (p_gated) else $error("factor not gated");
    property p_pulse;
        temp_done_o |=> !temp_done_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_changed;
        $changed(temperature_o) |-> ##[0:2] temp_done_o;
    endproperty
    a_changed: assert property (p_changed) else $error("no done after store");
    property p_done;
        temp_valid_i && zero_reg != 0 && coeff_reg != 0 |-> ##[2:200] temp_done_o;
    endproperty
    a_done: assert property (p_done) else $error("no result");
    property p_zero;
        temp_valid_i && (zero_reg == 0 || coeff_reg == 0)
            |=> (!temp_done_o && $stable(temperature_o)) [*8];
    endproperty
    a_zero: assert property (p_zero) else $error("zero divisor used");
    c_cfg: cover property (wr_acc && paddr_i == 8'h00);
    c_done: cover property (temp_done_o);
    c_err: cover property (pready_o && pslverr_o);
endmodule : trc_top_asserts
bind trc_top trc_top_asserts #(.FACT_W(FACT_W)) i_trc_asserts (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .temp_valid_i(temp_valid_i), .comp_active_o(comp_active_o),
    .internal_sensor_o(internal_sensor_o), .gain_drift_factor_o(gain_drift_factor_o),
    .offset_drift_factor_o(offset_drift_factor_o), .temperature_o(temperature_o),
    .temp_done_o(temp_done_o)
);
`default_nettype wire

// ===== tb/temp_ratio_compensation_tb_top.sv
`default_nettype none
module temp_ratio_compensation_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic tvalid = 1'b0;
    logic [19:0] tword = 20'h0;
    logic [31:0] prdata;
    logic pready, pslverr, comp_act, int_sel, tdone;
    logic [23:0] gain_f, offs_f, temp;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] rst_tab [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h00100000, 32'h000DAC00,
        32'h0, 32'h0, 32'h0};
    trc_top i_dut (
        .clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .temp_valid_i(tvalid), .temp_word_i(tword),
        .comp_active_o(comp_act), .internal_sensor_o(int_sel), .gain_drift_factor_o(gain_f),
        .offset_drift_factor_o(offs_f), .temperature_o(temp), .temp_done_o(tdone)
    );
    always #2 clk = ~clk;
    // ****
    // Bus and check tasks
    // ****
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Answer taken at the rising edge that samples ready; the global limit ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, exp);
        check({31'h0, e}, {31'h0, ee});
    endtask : rd
    task automatic measure(input logic [19:0] w);
        @(posedge clk);
        tvalid <= 1'b1;
        tword <= w;
        @(posedge clk);
        tvalid <= 1'b0;
    endtask : measure
    task automatic wait_done(input logic exp);
        int n = 0;
        // Step first so a pulse already seen is not counted twice
        do
        begin
            @(negedge clk);
            n++;
        end
        while (tdone !== 1'b1 && n < 200);
        check({31'h0, tdone}, {31'h0, exp});
    endtask : wait_done
    task automatic temp_run(input logic [19:0] w, input logic [31:0] exp);
        measure(w);
        wait_done(1'b1);
        check({8'h0, temp}, exp);
        rd(8'h0C, {12'h0, w}, 1'b0);
        rd(8'h20, exp, 1'b0);
    endtask : temp_run
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    // ****
    // Scenarios
    // ****
    initial
    begin
        int i;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        for (i = 0; i < 9; i++)
            rd(8'(4 * i), rst_tab[i], 1'b0);
        wr(8'h24, 32'hFFFFFFFF);
        rd(8'h24, 32'h0, 1'b1);
        wr(8'h04, 32'hFFFFFFFF);
        rd(8'h04, 32'h00FFFFFF, 1'b0);
        wr(8'h08, 32'h00123456);
        for (i = 0; i < 4; i++)
        begin
            wr(8'h00, {23'h0, i[1], 1'b0, i[0], 6'h0});
            repeat (3) @(negedge clk);
            check({31'h0, comp_act}, {31'h0, i[0]});
            check({31'h0, int_sel}, {31'h0, i[1]});
            check({8'h0, gain_f}, i[0] ? 32'h00FFFFFF : 32'h0);
            check({8'h0, offs_f}, i[0] ? 32'h00123456 : 32'h0);
        end
        rd(8'h00, 32'h00000140, 1'b0);
        wr(8'h0C, 32'h000FFFFF);
        rd(8'h0C, 32'h0, 1'b0);
        wr(8'h14, 32'h003D0900);
        temp_run(20'h00640, 32'h00000019);
        rd(8'h1C, 32'h2, 1'b0);
        wr(8'h1C, 32'h2);
        rd(8'h1C, 32'h0, 1'b0);
        wr(8'h10, 32'h00104000);
        temp_run(20'h0269C, 32'h00FFFF9C);
        wr(8'h10, 32'h00100000);
        wr(8'h14, 32'h00000100);
        temp_run(20'hFFFFF, 32'h007FFFFF);
        wr(8'h14, 32'h003D0900);
        measure(20'h00640);
        repeat (5) @(posedge clk);
        measure(20'h00C80);
        wait_done(1'b1);
        wait_done(1'b1);
        rd(8'h20, 32'h32, 1'b0);
        wr(8'h14, 32'h007A1200);
        wr(8'h18, 32'h1);
        wait_done(1'b1);
        rd(8'h20, 32'h19, 1'b0);
        for (i = 0; i < 2; i++)
        begin
            wr(8'h1C, 32'h3);
            wr(i ? 8'h14 : 8'h10, 32'h0);
            measure(20'h00640);
            wait_done(1'b0);
            rd(8'h1C, 32'h1, 1'b0);
            rd(8'h20, 32'h19, 1'b0);
            wr(8'h10, 32'h00100000);
            wr(8'h14, 32'h007A1200);
        end
        tally_and_finish();
    end
endmodule : temp_ratio_compensation_tb_top
`default_nettype wire
